// >>> design/nld_pkg.sv
package nld_pkg;
   // ------------------------------------------------------------
   // Sizes and indices
   // ------------------------------------------------------------
   localparam int NUM_PHASES = 3;
   localparam int NUM_CIRCUITS = 3;
   localparam int CIRC_TOTAL = 0;
   localparam int CIRC_FUND = 1;
   localparam int CIRC_APPARENT = 2;
   localparam int THR_W = 16;
   localparam int STATE_W = 16;
   localparam int TICK_W = 16;
   localparam int FLAG_W = 3;
   // Status and mask bit positions
   localparam int FLAG_TOTAL_BIT = 0;
   localparam int FLAG_FUND_BIT = 1;
   localparam int FLAG_APPARENT_BIT = 2;
   // Phase state field positions
   localparam int STATE_TOTAL_LSB = 0;
   localparam int STATE_FUND_LSB = 3;
   localparam int STATE_APPARENT_LSB = 6;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int IDLE_TICK_NS = 1000;
   localparam int IDLE_TICK_CYCLES = (IDLE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ------------------------------------------------------------
   // Reset values, zero and step constants
   // ------------------------------------------------------------
   localparam logic [THR_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [TICK_W-1:0] TICK_RESET = 16'h0000;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h0;
   localparam logic IRQ_N_RESET = 1'b1;
   localparam logic [THR_W-1:0] THR_ZERO = 16'h0000;
   localparam logic [THR_W-1:0] CNT_STEP = 16'h0001;
   localparam logic [TICK_W-1:0] TICK_STEP = 16'h0001;
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_PHASES-1:0] total_active;
      logic [NUM_PHASES-1:0] total_reactive;
      logic [NUM_PHASES-1:0] fund_active;
      logic [NUM_PHASES-1:0] fund_reactive;
      logic [NUM_PHASES-1:0] apparent;
   } nld_lsb_type;
   typedef struct packed {
      logic [THR_W-1:0] active_idle_threshold;
      logic [THR_W-1:0] reactive_idle_threshold;
      logic [THR_W-1:0] apparent_idle_threshold;
   } nld_thr_type;
   typedef struct packed {
      logic [NUM_CIRCUITS-1:0][NUM_PHASES-1:0][THR_W-1:0] cnt;
      logic [NUM_CIRCUITS-1:0][NUM_PHASES-1:0] idle;
      logic [FLAG_W-1:0] flag;
      logic [TICK_W-1:0] tick_cnt;
      logic irq_n;
   } nld_state_type;
endpackage : nld_pkg

// >>> design/nld_detector.sv
`timescale 1ns/1ns
// Overview of operation
// [R1] Total idle after thresholds pass without LSBs
// [R2] Total idle phase blocks accumulation and pulses
// [R3] Software computes thresholds from full-scale formula
// [R4] Both active/reactive thresholds zero disables total
// [R5] One threshold zero disables, accumulates freely
// [R6] Total event sets flag bit 0, bits 2:0
// [R7] Mask bit 0 drives interrupt low
// [R8] Write one clears flag, releases interrupt
// [R9] Fundamental idle blocks fundamental energies, pulses
// [R10] Fundamental disabled when either threshold zero
// [R11] Fundamental event sets flag 1, bits 5:3
// [R12] Mask bit 1 drives interrupt low
// [R13] Apparent idle blocks apparent energy, pulses
// [R14] Apparent threshold zero disables apparent circuit
// [R15] Apparent event sets flag 2, bits 8:6
// [R16] Mask bit 2 drives interrupt low
// [R17] Flags set regardless of mask
// [R18] Interrupt low until enabled flags cleared
// [R19] Per-phase idle counter restarts on LSB
// [R20] LSB ends idle, exit flagged
module nld_detector #(
   parameter int TICK_CYCLES = nld_pkg::IDLE_TICK_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire nld_pkg::nld_thr_type thr_i,
   input wire nld_pkg::nld_lsb_type lsb_i,
   input wire logic [nld_pkg::FLAG_W-1:0] second_mask_reg_i,
   input wire logic status_clear_we_i,
   input wire logic [nld_pkg::FLAG_W-1:0] status_clear_data_i,
   output logic [nld_pkg::NUM_PHASES-1:0] total_acc_enable_o,
   output logic [nld_pkg::NUM_PHASES-1:0] fund_acc_enable_o,
   output logic [nld_pkg::NUM_PHASES-1:0] apparent_acc_enable_o,
   output logic [nld_pkg::FLAG_W-1:0] second_status_reg_o,
   output logic [nld_pkg::STATE_W-1:0] phase_idle_state_o,
   output logic second_interrupt_line_n_o
);
   import nld_pkg::*;

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   generate
      if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
         $error("TICK_CYCLES out of range");
      end
   endgenerate

   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // ------------------------------------------------------------
   // Circuit inputs
   // ------------------------------------------------------------
   logic [NUM_CIRCUITS-1:0] en;
   logic [NUM_CIRCUITS-1:0][THR_W-1:0] thr;
   logic [NUM_CIRCUITS-1:0][NUM_PHASES-1:0] lsb;
   logic [THR_W-1:0] pair_thr;
   logic [FLAG_W-1:0] evt;
   logic [FLAG_W-1:0] clr;
   logic tick;
   nld_state_type r;
   nld_state_type nxt;

   assign pair_thr = (thr_i.active_idle_threshold > thr_i.reactive_idle_threshold) ?
                     thr_i.active_idle_threshold : thr_i.reactive_idle_threshold;
   // Pair circuits run only with both thresholds nonzero
   assign en[CIRC_TOTAL] = (thr_i.active_idle_threshold != THR_ZERO) &&
                           (thr_i.reactive_idle_threshold != THR_ZERO); // see [R4] see [R5]
   assign en[CIRC_FUND] = en[CIRC_TOTAL]; // see [R10]
   assign en[CIRC_APPARENT] = thr_i.apparent_idle_threshold != THR_ZERO; // see [R14]
   assign thr[CIRC_TOTAL] = pair_thr;
   assign thr[CIRC_FUND] = pair_thr;
   assign thr[CIRC_APPARENT] = thr_i.apparent_idle_threshold;
   assign lsb[CIRC_TOTAL] = lsb_i.total_active | lsb_i.total_reactive;
   assign lsb[CIRC_FUND] = lsb_i.fund_active | lsb_i.fund_reactive;
   assign lsb[CIRC_APPARENT] = lsb_i.apparent;
   assign clr = status_clear_we_i ? status_clear_data_i : FLAG_RESET;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt = r;
      evt = FLAG_RESET;
      tick = (r.tick_cnt == TICK_LAST);
      nxt.tick_cnt = tick ? TICK_RESET : r.tick_cnt + TICK_STEP;
      for (int c = 0; c < NUM_CIRCUITS; c++) begin
         for (int p = 0; p < NUM_PHASES; p++) begin
            if (!en[c] || lsb[c][p]) begin
               // LSB restarts counting and ends idle
               nxt.cnt[c][p] = CNT_RESET; // see [R19] see [R20]
               nxt.idle[c][p] = 1'b0;
            end else begin
               if (tick && (r.cnt[c][p] < thr[c])) begin
                  nxt.cnt[c][p] = r.cnt[c][p] + CNT_STEP; // see [R19]
               end
               nxt.idle[c][p] = (nxt.cnt[c][p] >= thr[c]); // see [R1] see [R9] see [R13]
            end
            if (nxt.idle[c][p] != r.idle[c][p]) begin
               evt[c] = 1'b1; // see [R6] see [R11] see [R15] see [R20]
            end
         end
      end
      // Set wins over clear, mask not involved
      nxt.flag = (r.flag & ~clr) | evt; // see [R8] see [R17]
      nxt.irq_n = ~|(nxt.flag & second_mask_reg_i); // see [R7] see [R12] see [R16] see [R18]
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r.cnt <= '0;
         r.idle <= '0;
         r.flag <= FLAG_RESET;
         r.tick_cnt <= TICK_RESET;
         r.irq_n <= IRQ_N_RESET;
      end else begin
         r <= nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign total_acc_enable_o = ~r.idle[CIRC_TOTAL]; // see [R2]
   assign fund_acc_enable_o = ~r.idle[CIRC_FUND]; // see [R9]
   assign apparent_acc_enable_o = ~r.idle[CIRC_APPARENT]; // see [R13]
   assign second_status_reg_o = r.flag;
   always_comb begin
      phase_idle_state_o = '0;
      phase_idle_state_o[STATE_TOTAL_LSB +: NUM_PHASES] = r.idle[CIRC_TOTAL]; // see [R6]
      phase_idle_state_o[STATE_FUND_LSB +: NUM_PHASES] = r.idle[CIRC_FUND]; // see [R11]
      phase_idle_state_o[STATE_APPARENT_LSB +: NUM_PHASES] = r.idle[CIRC_APPARENT]; // see [R15]
   end
   assign second_interrupt_line_n_o = r.irq_n;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_total_disabled;
      !en[CIRC_TOTAL] |=> (total_acc_enable_o == 3'h7) && (fund_acc_enable_o == 3'h7);
   endproperty
   a_total_disabled: assert property (p_total_disabled) else $error("pair circuit idle while disabled"); // see [R5]

   property p_both_zero;
      (thr_i.active_idle_threshold == THR_ZERO) && (thr_i.reactive_idle_threshold == THR_ZERO)
         |=> (phase_idle_state_o[5:0] == 6'h00);
   endproperty
   a_both_zero: assert property (p_both_zero) else $error("pair state set with zero thresholds"); // see [R4]

   property p_apparent_disabled;
      !en[CIRC_APPARENT] |=> (phase_idle_state_o[8:6] == 3'h0);
   endproperty
   a_apparent_disabled: assert property (p_apparent_disabled) else $error("apparent idle while disabled"); // see [R14]

   property p_lsb_exit;
      lsb[CIRC_TOTAL][0] |=> total_acc_enable_o[0] && !phase_idle_state_o[STATE_TOTAL_LSB];
   endproperty
   a_lsb_exit: assert property (p_lsb_exit) else $error("phase A stayed idle after an LSB"); // see [R20]

   property p_idle_needs_time;
      $rose(r.idle[CIRC_APPARENT][1]) |-> (r.cnt[CIRC_APPARENT][1] >= thr[CIRC_APPARENT]);
   endproperty
   a_idle_needs_time: assert property (p_idle_needs_time) else $error("apparent idle too early"); // see [R19]

   property p_total_flag;
      (phase_idle_state_o[2:0] != $past(phase_idle_state_o[2:0])) |-> second_status_reg_o[FLAG_TOTAL_BIT];
   endproperty
   a_total_flag: assert property (p_total_flag) else $error("total change not flagged"); // see [R6]

   property p_fund_flag;
      (phase_idle_state_o[5:3] != $past(phase_idle_state_o[5:3])) |-> second_status_reg_o[FLAG_FUND_BIT];
   endproperty
   a_fund_flag: assert property (p_fund_flag) else $error("fundamental change not flagged"); // see [R11]

   property p_apparent_flag;
      (phase_idle_state_o[8:6] != $past(phase_idle_state_o[8:6])) |-> second_status_reg_o[FLAG_APPARENT_BIT];
   endproperty
   a_apparent_flag: assert property (p_apparent_flag) else $error("apparent change not flagged"); // see [R15]

   property p_irq_low;
      (|(second_status_reg_o & second_mask_reg_i)) && !status_clear_we_i && $stable(second_mask_reg_i)
         |=> !second_interrupt_line_n_o;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("interrupt not low with masked flag"); // see [R7]

   property p_irq_high;
      ##1 (second_interrupt_line_n_o == !(|(second_status_reg_o & $past(second_mask_reg_i))));
   endproperty
   a_irq_high: assert property (p_irq_high) else $error("interrupt level wrong"); // see [R18]

   property p_clear;
      status_clear_we_i && status_clear_data_i[FLAG_FUND_BIT] && !evt[FLAG_FUND_BIT]
         |=> !second_status_reg_o[FLAG_FUND_BIT];
   endproperty
   a_clear: assert property (p_clear) else $error("write one did not clear"); // see [R8]

   property p_set_wins;
      status_clear_we_i && status_clear_data_i[FLAG_TOTAL_BIT] && evt[FLAG_TOTAL_BIT]
         |=> second_status_reg_o[FLAG_TOTAL_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost under clear"); // see [R8]

   property p_masked_flag;
      !second_mask_reg_i[FLAG_APPARENT_BIT] && evt[FLAG_APPARENT_BIT] |=> second_status_reg_o[FLAG_APPARENT_BIT];
   endproperty
   a_masked_flag: assert property (p_masked_flag) else $error("masked event not flagged"); // see [R17]

   property p_total_enter;
      $rose(phase_idle_state_o[STATE_TOTAL_LSB]) |-> $past(en[CIRC_TOTAL]) && !$past(lsb[CIRC_TOTAL][0]);
   endproperty
   a_total_enter: assert property (p_total_enter) else $error("total idle entered after an LSB"); // see [R1]

   property p_fund_enter;
      $rose(phase_idle_state_o[STATE_FUND_LSB + 1]) |-> $past(en[CIRC_FUND]) && !$past(lsb[CIRC_FUND][1]);
   endproperty
   a_fund_enter: assert property (p_fund_enter) else $error("fundamental idle entered after an LSB"); // see [R9]

   property p_apparent_enter;
      $rose(phase_idle_state_o[STATE_APPARENT_LSB + 2]) |-> $past(en[CIRC_APPARENT]) && !$past(lsb[CIRC_APPARENT][2]);
   endproperty
   a_apparent_enter: assert property (p_apparent_enter) else $error("apparent idle entered after an LSB"); // see [R13]

   property p_total_block;
      en[CIRC_TOTAL] && !lsb[CIRC_TOTAL][1] && $stable(thr_i) && !total_acc_enable_o[1]
         |=> !total_acc_enable_o[1];
   endproperty
   a_total_block: assert property (p_total_block) else $error("total idle released without LSB"); // see [R2]

   property p_fund_block;
      en[CIRC_FUND] && !lsb[CIRC_FUND][2] && $stable(thr_i) && !fund_acc_enable_o[2]
         |=> !fund_acc_enable_o[2];
   endproperty
   a_fund_block: assert property (p_fund_block) else $error("fundamental idle released without LSB"); // see [R9]

   property p_apparent_block;
      en[CIRC_APPARENT] && !lsb[CIRC_APPARENT][0] && $stable(thr_i) && !apparent_acc_enable_o[0]
         |=> !apparent_acc_enable_o[0];
   endproperty
   a_apparent_block: assert property (p_apparent_block) else $error("apparent idle released without LSB"); // see [R13]

   property p_reactive_zero;
      (thr_i.active_idle_threshold != THR_ZERO) && (thr_i.reactive_idle_threshold == THR_ZERO)
         |=> (total_acc_enable_o == {NUM_PHASES{1'b1}});
   endproperty
   a_reactive_zero: assert property (p_reactive_zero) else $error("total blocked with one zero threshold"); // see [R5]

   property p_active_zero;
      (thr_i.active_idle_threshold == THR_ZERO) && (thr_i.reactive_idle_threshold != THR_ZERO)
         |=> (fund_acc_enable_o == {NUM_PHASES{1'b1}});
   endproperty
   a_active_zero: assert property (p_active_zero) else $error("fundamental blocked with one zero threshold"); // see [R10]

   property p_total_sticky;
      second_status_reg_o[FLAG_TOTAL_BIT] && !(status_clear_we_i && status_clear_data_i[FLAG_TOTAL_BIT])
         |=> second_status_reg_o[FLAG_TOTAL_BIT];
   endproperty
   a_total_sticky: assert property (p_total_sticky) else $error("total flag lost without clear"); // see [R8]

   property p_irq_hold;
      !second_interrupt_line_n_o && !status_clear_we_i && $stable(second_mask_reg_i)
         |=> !second_interrupt_line_n_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without clear"); // see [R18]

   property p_irq_unmasked;
      (second_mask_reg_i == FLAG_RESET) |=> second_interrupt_line_n_o;
   endproperty
   a_irq_unmasked: assert property (p_irq_unmasked) else $error("interrupt low with all masks off"); // see [R17]

   property p_fund_irq;
      second_status_reg_o[FLAG_FUND_BIT] && second_mask_reg_i[FLAG_FUND_BIT] && !status_clear_we_i
         |=> !second_interrupt_line_n_o;
   endproperty
   a_fund_irq: assert property (p_fund_irq) else $error("fundamental flag did not pull interrupt"); // see [R12]

   property p_apparent_irq;
      second_status_reg_o[FLAG_APPARENT_BIT] && second_mask_reg_i[FLAG_APPARENT_BIT] && !status_clear_we_i
         |=> !second_interrupt_line_n_o;
   endproperty
   a_apparent_irq: assert property (p_apparent_irq) else $error("apparent flag did not pull interrupt"); // see [R16]

   property p_fund_exit;
      lsb[CIRC_FUND][2] |=> fund_acc_enable_o[2] && !phase_idle_state_o[STATE_FUND_LSB + 2];
   endproperty
   a_fund_exit: assert property (p_fund_exit) else $error("fundamental phase C stayed idle"); // see [R20]

   property p_cnt_restart;
      lsb[CIRC_APPARENT][0] |=> (r.cnt[CIRC_APPARENT][0] == CNT_RESET);
   endproperty
   a_cnt_restart: assert property (p_cnt_restart) else $error("idle counter not restarted"); // see [R19]

   property p_cnt_hold;
      en[CIRC_TOTAL] && !lsb[CIRC_TOTAL][2] && (r.cnt[CIRC_TOTAL][2] >= thr[CIRC_TOTAL])
         |=> $stable(r.cnt[CIRC_TOTAL][2]);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("idle counter ran past threshold"); // see [R19]

   // ------------------------------------------------------------
   // Covers
   // ------------------------------------------------------------
   c_total_enter: cover property ($rose(phase_idle_state_o[STATE_TOTAL_LSB]));
   c_apparent_exit: cover property ($fell(phase_idle_state_o[STATE_APPARENT_LSB]));
   c_irq_low: cover property ($fell(second_interrupt_line_n_o));
   c_set_wins: cover property (status_clear_we_i && (|(status_clear_data_i & evt)));
   c_fund_exit: cover property ($fell(phase_idle_state_o[STATE_FUND_LSB + 1]));
endmodule : nld_detector

// >>> bench/nld_acc_model.sv
`timescale 1ns/1ns
module nld_acc_model (
   input wire logic sys_clk_i,
   input wire logic [14:0] active_i,
   output nld_pkg::nld_lsb_type lsb_o
);
   import nld_pkg::*;
   initial begin
      lsb_o = '0;
   end
   // ------------------------------------------------------------
   // Busy streams hand one LSB to their accumulator every cycle
   // ------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      lsb_o <= active_i;
   end
endmodule : nld_acc_model

// >>> bench/polyphase_no_load_detector_tb.sv
`timescale 1ns/1ns
module polyphase_no_load_detector_tb;
   import nld_pkg::*;
   logic sys_clk;
   logic sys_rst;
   nld_thr_type thr;
   nld_lsb_type lsb;
   logic [14:0] busy;
   logic [2:0] mask;
   logic clr_we;
   logic [2:0] clr_data;
   logic [2:0] tot_en;
   logic [2:0] fund_en;
   logic [2:0] app_en;
   logic [2:0] status;
   logic [15:0] state;
   logic irq_n;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int t;
   int r;
   logic [47:0] dis_tab [3] = '{48'h0, 48'h0005_0000_0000, 48'h0000_0005_0000};
   nld_detector #(.TICK_CYCLES(1)) dut_u (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .thr_i(thr), .lsb_i(lsb),
      .second_mask_reg_i(mask), .status_clear_we_i(clr_we), .status_clear_data_i(clr_data),
      .total_acc_enable_o(tot_en), .fund_acc_enable_o(fund_en), .apparent_acc_enable_o(app_en),
      .second_status_reg_o(status), .phase_idle_state_o(state), .second_interrupt_line_n_o(irq_n));
   nld_acc_model far_u (.sys_clk_i(sys_clk), .active_i(busy), .lsb_o(lsb));
   // ------------------------------------------------------------
   // Clock and timeout
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_fail++;
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // Expectation and compare helpers
   // ------------------------------------------------------------
   function automatic logic [14:0] quiet_bits(input int c, input int p);
      quiet_bits = (c == CIRC_APPARENT) ? (15'h0001 << p) : (15'h0009 << (3 + p + 6 * (1 - c)));
   endfunction : quiet_bits
   function automatic logic [15:0] idle_bit(input int c, input int p);
      idle_bit = 16'h0001 << (3 * c + p);
   endfunction : idle_bit
   // Host threshold from the full-scale to idle current ratio
   function automatic int idle_thr_from_ratio(input longint y, input longint stage_one);
      idle_thr_from_ratio = int'(64'd65535 - (y * stage_one * 64'd131072) / 64'd26991271);
   endfunction : idle_thr_from_ratio
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_all(input logic [15:0] st, input logic [2:0] fl, input logic irq);
      chk(state, st);
      chk(16'({app_en, fund_en, tot_en}), {7'h00, ~st[8:0]});
      chk(16'(status), 16'(fl));
      chk(16'(irq_n), 16'(irq));
   endtask : chk_all
   task automatic clear_flags(input logic [2:0] bits);
      @(negedge sys_clk);
      clr_data = bits;
      clr_we = 1'b1;
      @(negedge sys_clk);
      clr_we = 1'b0;
   endtask : clear_flags
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      thr = '0;
      busy = 15'h7fff;
      mask = 3'h0;
      clr_we = 1'b0;
      clr_data = 3'h0;
      r = $urandom(3);
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      chk_all(16'h0000, 3'h0, 1'b1);
      sys_rst = 1'b0;
      for (int c = 0; c < 3; c++) begin
         for (int p = 0; p < 3; p++) begin
            t = (c == 0 && p == 0) ? idle_thr_from_ratio(1, 13495000) : 2 + $urandom_range(7);
            mask = (3'($urandom_range(7)) & ~(3'h1 << c)) | (3'(p & 1) << c);
            @(negedge sys_clk);
            thr = {16'(t), 16'(1 + $urandom_range(t - 1)), 16'(t)};
            clear_flags(3'h7);
            busy = 15'h7fff ^ quiet_bits(c, p);
            repeat (t - 1) @(negedge sys_clk);
            chk_all(16'h0000, 3'h0, 1'b1);
            clear_flags(3'h7);
            repeat (3) @(negedge sys_clk);
            chk_all(idle_bit(c, p), 3'h1 << c, !mask[c]);
            busy = 15'h7fff;
            repeat (2) @(negedge sys_clk);
            chk_all(16'h0000, 3'h1 << c, !mask[c]);
            clear_flags(3'h1 << c);
            chk_all(16'h0000, 3'h0, 1'b1);
            $display("test idle circuit %0d phase %0d thr %0d done", c, p, t);
         end
      end
      for (int i = 0; i < 3; i++) begin
         mask = (i == 1) ? 3'h7 : 3'h0;
         busy = 15'h7fff;
         @(negedge sys_clk);
         thr = dis_tab[i];
         clear_flags(3'h7);
         busy = 15'h0000;
         repeat (20) @(negedge sys_clk);
         chk_all(16'h0000, 3'h0, 1'b1);
         $display("test disabled set %0d done", i);
      end
      give_verdict();
   end
endmodule : polyphase_no_load_detector_tb
